// file: hdl/rss_reset_standby.sv
// Reset sequencer with reset pad filter, brownout pad control and standby supply handshake.
`timescale 1ns/10ps

module rss_reset_standby #(
    parameter int FUNC_CYCLES = rss_pkg::FUNC_RESET_CYCLES,
    parameter int DESTR_CYCLES = rss_pkg::DESTR_RESET_CYCLES,
    parameter int POR_CYCLES = rss_pkg::POR_RESET_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Pins from the power IC and board
    input wire rss_pkg::rss_pins_t pinsIn,
    input wire logic coreBrownout,
    // Requests from the system
    input wire logic destructiveReq,
    input wire logic functionalReq,
    input wire logic standbyReq,
    // Reset pad drive, output enable is active low
    output logic resetPadOut,
    output logic resetPadOe_n,
    // Status and standby pin
    output logic standby_request_out_n,
    output logic inReset,
    output logic [rss_pkg::TOTAL_W-1:0] totalResetCycles
);
    import rss_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    rss_pins_t syncA_reg;
    rss_pins_t syncB_reg;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncA_reg <= 3'h6;
            syncB_reg <= 3'h6;
        end
        else
        begin
            syncA_reg <= pinsIn;
            syncB_reg <= syncA_reg;
        end
    end

    wire logic porActive = !syncB_reg.porN;
    wire logic supplyGood = syncB_reg.supplyGood;

    // ----------------------------------------
    // Reset pad filter
    // ----------------------------------------
    logic [3:0] padLowCnt_reg;
    logic padReq;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            padLowCnt_reg <= 4'h0;
        else if (syncB_reg.resetPadN || !resetPadOe_n)
            padLowCnt_reg <= 4'h0;
        else if (padLowCnt_reg != 4'(FILTER_SAMPLES))
            padLowCnt_reg <= padLowCnt_reg + 4'h1;
    end

    // Our own drive is excluded so a sequence does not retrigger itself from the pad.
    // The request fires on the edge that takes the last of the required low samples.
    assign padReq = (padLowCnt_reg == 4'(FILTER_SAMPLES - 1)) && !syncB_reg.resetPadN && resetPadOe_n;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    rss_state_t state_reg;
    logic [CNT_W-1:0] seqCnt_reg;
    logic supplyLost;
    logic destrEvent;

    // Loss of supply-good outside standby without POR is treated as a power-on reset.
    assign supplyLost = !supplyGood && !porActive && (state_reg != RSS_STBY) && (state_reg != RSS_STBY_EXIT)
        && (state_reg != RSS_STBY_ENTRY);
    assign destrEvent = destructiveReq || coreBrownout;

    function automatic logic [CNT_W-1:0] seqLen(input rss_state_t s);
        case (s)
            RSS_FUNC: seqLen = CNT_W'(FUNC_CYCLES - 1);
            // The functional phase that follows is part of the whole sequence, so it is taken off here.
            RSS_DESTR: seqLen = CNT_W'(DESTR_CYCLES - FUNC_CYCLES - 1);
            RSS_POR: seqLen = CNT_W'(POR_CYCLES - FUNC_CYCLES - 1);
            default: seqLen = '0;
        endcase
    endfunction

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= RSS_POR;
            seqCnt_reg <= '0;
        end
        else if (porActive || supplyLost || (state_reg == RSS_STBY_ENTRY && porActive))
        begin
            state_reg <= RSS_POR;
            seqCnt_reg <= '0;
        end
        else if (destrEvent && state_reg != RSS_DESTR)
        begin
            state_reg <= RSS_DESTR;
            seqCnt_reg <= '0;
        end
        else if (destrEvent)
        begin
            seqCnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                RSS_FUNC, RSS_DESTR, RSS_POR:
                begin
                    if (seqCnt_reg == seqLen(state_reg))
                    begin
                        // Destructive and power-on sequences run on into the functional phase.
                        state_reg <= (state_reg == RSS_FUNC) ? RSS_RUN : RSS_FUNC;
                        seqCnt_reg <= '0;
                    end
                    else
                        seqCnt_reg <= seqCnt_reg + 1'b1;
                end
                RSS_RUN:
                begin
                    if (padReq || functionalReq)
                        state_reg <= RSS_FUNC;
                    else if (standbyReq)
                        state_reg <= RSS_STBY_ENTRY;
                end
                RSS_STBY_ENTRY:
                begin
                    if (!supplyGood)
                        state_reg <= RSS_STBY;
                end
                RSS_STBY:
                begin
                    if (!standbyReq)
                        state_reg <= RSS_STBY_EXIT;
                end
                RSS_STBY_EXIT:
                begin
                    if (supplyGood)
                        state_reg <= RSS_RUN;
                end
                default: state_reg <= RSS_POR;
            endcase
        end
    end

    // ----------------------------------------
    // Total time in reset
    // ----------------------------------------
    // The total survives restarts and clears only when a fresh reset begins outside a sequence.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            totalResetCycles <= '0;
        else if (state_reg == RSS_FUNC || state_reg == RSS_DESTR || state_reg == RSS_POR)
            totalResetCycles <= totalResetCycles + 1'b1;
        else if (destrEvent || porActive || supplyLost || (state_reg == RSS_RUN && (padReq || functionalReq)))
            totalResetCycles <= '0;
    end

    // ----------------------------------------
    // Pad drive and outputs
    // ----------------------------------------
    logic [2:0] hizCnt_reg;
    logic resetting;

    assign resetting = (state_reg == RSS_FUNC || state_reg == RSS_DESTR || state_reg == RSS_POR);

    // On brownout or core droop the pad floats while it lasts and 4 cycles after, before being pulled low.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            hizCnt_reg <= '0;
        else if (coreBrownout)
            hizCnt_reg <= 3'(HIZ_CYCLES);
        else if (hizCnt_reg != 3'h0)
            hizCnt_reg <= hizCnt_reg - 3'h1;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            resetPadOut <= 1'b0;
            resetPadOe_n <= 1'b1;
            inReset <= 1'b1;
            standby_request_out_n <= 1'b1;
        end
        else
        begin
            resetPadOut <= 1'b0;
            resetPadOe_n <= !(resetting && hizCnt_reg == 3'h0 && !coreBrownout);
            inReset <= resetting;
            standby_request_out_n <= !(state_reg == RSS_STBY_ENTRY || state_reg == RSS_STBY);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_por_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
        porActive |=> state_reg == RSS_POR && seqCnt_reg == '0)
        else $error("POR did not restart sequence");
    a_total_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
        resetting |=> totalResetCycles == $past(totalResetCycles) + 24'h1)
        else $error("Reset total lost");
    a_seq_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
        seqCnt_reg <= seqLen(state_reg))
        else $error("Sequence count over bound");
    a_pad_filter: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == RSS_RUN && padReq && !porActive && !supplyLost && !destrEvent) |=> state_reg == RSS_FUNC)
        else $error("Filtered pad request ignored");
    a_brown_hiz: assert property (@(posedge ref_clk) disable iff (!rst_n)
        coreBrownout |=> resetPadOe_n)
        else $error("Pad driven during brownout float");
    a_droop_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(coreBrownout) ##0 !porActive |-> ##[1:8] !resetPadOe_n)
        else $error("Pad not driven low after droop");
    a_stby_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == RSS_STBY) |=> !standby_request_out_n)
        else $error("Standby request not asserted");
    a_supply_por: assert property (@(posedge ref_clk) disable iff (!rst_n)
        supplyLost |=> state_reg == RSS_POR)
        else $error("Supply loss did not start POR");
    a_stby_abort: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == RSS_STBY_ENTRY && porActive) |=> state_reg == RSS_POR ##1 standby_request_out_n)
        else $error("Standby entry not aborted by POR");
    a_sync_path: assert property (@(posedge ref_clk) disable iff (!rst_n)
        syncB_reg == $past(syncA_reg))
        else $error("Synchroniser stage skipped");

endmodule

// file: hdl/rss_pkg.sv
// Package with constants and types for the reset and standby supply handshake block.
package rss_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int FUNC_RESET_TIME_US = 545;
    localparam int DESTR_RESET_TIME_US = 1370;
    localparam int POR_RESET_TIME_US = 1500;
    // All times convert to whole cycles exactly, with no rounding.
    localparam int FUNC_RESET_CYCLES = FUNC_RESET_TIME_US * CLK_MHZ;
    localparam int DESTR_RESET_CYCLES = DESTR_RESET_TIME_US * CLK_MHZ;
    localparam int POR_RESET_CYCLES = POR_RESET_TIME_US * CLK_MHZ;
    localparam int GLITCH_REJECT_NS = 17;
    localparam int MIN_ACCEPT_NS = 400;
    localparam int CLK_PERIOD_NS = 50;
    // Pulses of up to 17 ns cannot span a 50 ns sample reliably; require a run of samples
    // no longer than the shortest accepted pulse (400 ns divides to exactly 8 samples).
    localparam int FILTER_SAMPLES = MIN_ACCEPT_NS / CLK_PERIOD_NS;
    localparam int HIZ_CYCLES = 4;
    localparam int CNT_W = 16;
    localparam int TOTAL_W = 24;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        RSS_RUN = 3'b000,
        RSS_FUNC = 3'b001,
        RSS_DESTR = 3'b011,
        RSS_POR = 3'b010,
        RSS_STBY_ENTRY = 3'b110,
        RSS_STBY = 3'b111,
        RSS_STBY_EXIT = 3'b101
    } rss_state_t;

    typedef struct packed {
        logic porN;
        logic resetPadN;
        logic supplyGood;
    } rss_pins_t;

endpackage

// file: verif/rss_pmic_model.sv
// Behavioural model of the power IC that drives the power-on reset and supply-good pins.
`timescale 1ns/10ps
module rss_pmic_model (
    // Clock
    input wire logic ref_clk,
    // From device and bench
    input wire logic standbyReqN,
    input wire logic fault,
    input wire logic dropGood,
    // To device
    output logic porN,
    output logic supplyGood
);
    int rampCnt = 0;
    int lowCnt = 0;
    int highCnt = 0;
    logic off = 1'b0;
    logic porNext;

    // The supplies ramp for 20 cycles; any detector fault pulls the power-on reset low.
    assign porNext = !(rampCnt < 20 || fault);
    always @(posedge ref_clk)
    begin
        rampCnt <= (rampCnt < 20) ? rampCnt + 1 : rampCnt;
        lowCnt <= standbyReqN ? 0 : lowCnt + 1;
        highCnt <= standbyReqN ? highCnt + 1 : 0;
        if (lowCnt == 12)
            off <= 1'b1;
        if (highCnt == 12)
            off <= 1'b0;
        porN <= porNext;
        supplyGood <= porNext && !dropGood && !off;
    end
endmodule

// file: verif/reset_and_standby_supply_handshake_bench.sv
// Self-checking bench for the reset sequencer and standby supply handshake.
`timescale 1ns/10ps
module reset_and_standby_supply_handshake_bench;
    localparam int FC = 20;
    localparam int DC = 30;
    localparam int PC = 40;
    localparam int PIN_PAD = 0;
    localparam int PIN_FUNC = 1;
    localparam int PIN_DESTR = 2;
    localparam int PIN_FAULT = 3;
    localparam int PIN_DROP = 4;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic padN = 1'b1;
    logic coreBrownout = 1'b0;
    logic destructiveReq = 1'b0;
    logic functionalReq = 1'b0;
    logic standbyReq = 1'b0;
    logic fault = 1'b0;
    logic dropGood = 1'b0;
    logic porN;
    logic good;
    logic resetPadOut;
    logic resetPadOe_n;
    logic standby_request_out_n;
    logic inReset;
    logic [23:0] totalResetCycles;
    rss_pkg::rss_pins_t pinsIn;
    int error_cnt = 0;
    int tests_run = 0;
    int seed = 32'h7e1a66b1;
    int n;

    assign pinsIn = {porN, padN, good};
    rss_reset_standby #(.FUNC_CYCLES(FC), .DESTR_CYCLES(DC), .POR_CYCLES(PC)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .pinsIn(pinsIn), .coreBrownout(coreBrownout),
        .destructiveReq(destructiveReq), .functionalReq(functionalReq), .standbyReq(standbyReq),
        .resetPadOut(resetPadOut), .resetPadOe_n(resetPadOe_n),
        .standby_request_out_n(standby_request_out_n), .inReset(inReset),
        .totalResetCycles(totalResetCycles));
    rss_pmic_model pmic (.ref_clk(ref_clk), .standbyReqN(standby_request_out_n), .fault(fault),
        .dropGood(dropGood), .porN(porN), .supplyGood(good));

    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    task automatic inRange(input string what, input int lo, input int hi, input logic [23:0] got);
        check(what, 24'h1, {23'h0, (got >= lo && got <= hi) === 1'b1});
    endtask

    task automatic waitLevel(input logic v, input int limit);
        int i;
        i = 0;
        while (inReset !== v && i < limit)
        begin
            tick(1);
            i++;
        end
        check("inReset level", {23'h0, v}, {23'h0, inReset});
    endtask

    task automatic drivePin(input int which, input logic v);
        case (which)
            PIN_PAD: padN <= v;
            PIN_FUNC: functionalReq <= v;
            PIN_DESTR: destructiveReq <= v;
            PIN_FAULT: fault <= v;
            default: dropGood <= v;
        endcase
    endtask

    // Holds one selected input at level v for k cycles, then returns it to the other level.
    task automatic pulse(input int which, input logic v, input int k);
        @(posedge ref_clk);
        drivePin(which, v);
        tick(k);
        drivePin(which, ~v);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        tick(5000);
        error_cnt++;
        tally_and_finish();
    end

    initial
    begin
        tick(16);
        rst_n <= 1'b1;
        waitLevel(1'b0, 400);
        inRange("power-on total", PC, PC + 12, totalResetCycles);
        for (int i = 0; i < 6; i++)
        begin
            pulse(PIN_PAD, 1'b0, 1 + ({$random(seed)} % 7));
            tick(8);
            check("glitch ignored", 24'h0, {23'h0, inReset});
        end
        pulse(PIN_PAD, 1'b0, 8 + ({$random(seed)} % 4));
        tick(6);
        check("pad accepted", 24'h1, {23'h0, inReset});
        waitLevel(1'b0, 200);
        pulse(PIN_FUNC, 1'b1, 1);
        waitLevel(1'b1, 10);
        n = 0;
        while (inReset === 1'b1 && n < 1000)
        begin
            tick(1);
            n++;
        end
        inRange("functional length", FC, FC + 4, 24'(n));
        pulse(PIN_DESTR, 1'b1, 1);
        tick(4);
        pulse(PIN_FAULT, 1'b1, 6);
        waitLevel(1'b0, 400);
        inRange("interrupted total", 4 + PC, 4 + PC + DC + FC + 20, totalResetCycles);
        @(posedge ref_clk);
        coreBrownout <= 1'b1;
        tick(4);
        check("brownout float", 24'h1, {23'h0, resetPadOe_n});
        coreBrownout <= 1'b0;
        tick(9);
        check("brownout drive", 24'h0, {23'h0, resetPadOe_n});
        check("pad drive level", 24'h0, {23'h0, resetPadOut});
        waitLevel(1'b0, 400);
        standbyReq <= 1'b1;
        tick(4);
        check("standby asserted", 24'h0, {23'h0, standby_request_out_n});
        tick(20);
        standbyReq <= 1'b0;
        tick(4);
        check("standby released", 24'h1, {23'h0, standby_request_out_n});
        tick(20);
        check("standby no reset", 24'h0, {23'h0, inReset});
        pulse(PIN_DROP, 1'b1, 4);
        tick(6);
        check("supply loss reset", 24'h1, {23'h0, inReset});
        waitLevel(1'b0, 400);
        standbyReq <= 1'b1;
        tick(4);
        pulse(PIN_FAULT, 1'b1, 6);
        standbyReq <= 1'b0;
        tick(2);
        check("entry aborted", 24'h1, {23'h0, inReset && standby_request_out_n});
        waitLevel(1'b0, 400);
        tally_and_finish();
    end
endmodule
